// *** verilog/eimrf_top.sv ***
// interrupt masks, mac status and receive filter configuration with apb
`timescale 1ns/1ps
`include "eimrf_defs.svh"

module eimrf_top
   import eimrf_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic HOST_ERR_EVT,
   input wire logic STATS_EVT,
   output logic MAC_INT,
   output logic [7:0] RX_CHAN_INT_ENABLE,
   output logic [31:0] RX_FILTER_CFG,
   input wire logic FRM_VALID,
   input wire logic [15:0] FRM_LEN,
   input wire logic [15:0] FRM_BUF_LEN,
   input wire logic FRM_IS_CTRL,
   input wire logic FRM_IS_PAUSE,
   input wire logic FRM_IS_SHORT,
   input wire logic FRM_HAS_ERR,
   input wire logic PAUSE_ACT_EN,
   output logic FRM_DONE,
   output logic FRM_STORE,
   output logic FRM_ACT_PAUSE,
   output logic [15:0] FRM_DESC_LEN,
   output logic [15:0] FRM_XFER_LEN
);

   function automatic eimrf_reg_t decode(input logic [7:0] a);
      eimrf_reg_t r;
      r = EIMRF_R_NONE;
      unique case (a)
         `EIMRF_OFS_RX_EN_SET: r = EIMRF_R_RX_EN_SET;
         `EIMRF_OFS_RX_DISABLE: r = EIMRF_R_RX_DISABLE;
         `EIMRF_OFS_RAW: r = EIMRF_R_RAW;
         `EIMRF_OFS_MASKED: r = EIMRF_R_MASKED;
         `EIMRF_OFS_EN_SET: r = EIMRF_R_EN_SET;
         `EIMRF_OFS_EN_CLR: r = EIMRF_R_EN_CLR;
         `EIMRF_OFS_STAT_CLR: r = EIMRF_R_STAT_CLR;
         `EIMRF_OFS_RX_CFG: r = EIMRF_R_RX_CFG;
         default: r = EIMRF_R_NONE;
      endcase
      return r;
   endfunction

   function automatic eimrf_len_t min_len(input eimrf_len_t a,
                                          input eimrf_len_t b);
      return (a < b) ? a : b;
   endfunction

   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [7:0] rx_int_enable_q;
   logic [1:0] mac_pend_q;
   logic [1:0] mac_enable_q;
   logic [31:0] rx_cfg_q;
   logic mac_int_q;
   logic frm_done_q;
   logic frm_store_q;
   logic frm_act_pause_q;
   logic [15:0] frm_desc_len_q;
   logic [15:0] frm_xfer_len_q;

   eimrf_reg_t sel;
   logic access;
   logic wr_go;
   logic [1:0] mac_masked;
   logic [31:0] rd_word;
   logic [15:0] desc_len;
   logic keep_fcs;
   logic copy_ok;

   assign sel = decode(PADDR);
   // one wait state: ready rises in the second access cycle
   assign access = PSEL & PENABLE & ~pready_q;
   assign wr_go = PSEL & PENABLE & pready_q & PWRITE;
   assign mac_masked = mac_pend_q & mac_enable_q;

   always_comb begin
      rd_word = `EIMRF_RST_WORD;
      unique case (sel)
         EIMRF_R_RX_EN_SET: rd_word[7:0] = rx_int_enable_q;
         EIMRF_R_RX_DISABLE: rd_word[7:0] = rx_int_enable_q;
         EIMRF_R_RAW: rd_word[1:0] = mac_pend_q;
         EIMRF_R_MASKED: rd_word[1:0] = mac_masked;
         EIMRF_R_EN_SET: rd_word[1:0] = mac_enable_q;
         EIMRF_R_EN_CLR: rd_word[1:0] = mac_enable_q;
         EIMRF_R_RX_CFG: rd_word = rx_cfg_q;
         EIMRF_R_STAT_CLR: rd_word = `EIMRF_RST_WORD;
         EIMRF_R_NONE: rd_word = `EIMRF_RST_WORD;
      endcase
   end

   // apb handshake and read data
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         pready_q <= 1'b0;
         prdata_q <= `EIMRF_RST_WORD;
         pslverr_q <= 1'b0;
      end else if (access) begin
         pready_q <= 1'b1;
         prdata_q <= PWRITE ? `EIMRF_RST_WORD : rd_word;
         pslverr_q <= (sel == EIMRF_R_NONE);
      end else begin
         pready_q <= 1'b0;
         prdata_q <= `EIMRF_RST_WORD;
         pslverr_q <= 1'b0;
      end
   end

   // receive channel interrupt enables
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         rx_int_enable_q <= `EIMRF_RST_RX_EN;
      end else if (wr_go && sel == EIMRF_R_RX_EN_SET) begin
         rx_int_enable_q <= rx_int_enable_q | PWDATA[7:0];
      end else if (wr_go && sel == EIMRF_R_RX_DISABLE) begin
         rx_int_enable_q <= rx_int_enable_q & ~PWDATA[7:0];
      end
   end

   // mac interrupt enables
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         mac_enable_q <= `EIMRF_RST_MAC;
      end else if (wr_go && sel == EIMRF_R_EN_SET) begin
         mac_enable_q[`EIMRF_BIT_HOST] <= mac_enable_q[`EIMRF_BIT_HOST]
            | PWDATA[`EIMRF_BIT_HOST];
         mac_enable_q[`EIMRF_BIT_STAT] <= mac_enable_q[`EIMRF_BIT_STAT]
            | PWDATA[`EIMRF_BIT_STAT];
      end else if (wr_go && sel == EIMRF_R_EN_CLR) begin
         mac_enable_q[`EIMRF_BIT_HOST] <= mac_enable_q[`EIMRF_BIT_HOST]
            & ~PWDATA[`EIMRF_BIT_HOST];
         mac_enable_q[`EIMRF_BIT_STAT] <= mac_enable_q[`EIMRF_BIT_STAT]
            & ~PWDATA[`EIMRF_BIT_STAT];
      end
   end

   // sticky pending bits; a new event wins over a clear in the same cycle
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         mac_pend_q <= `EIMRF_RST_MAC;
      end else begin
         if (HOST_ERR_EVT) begin
            mac_pend_q[`EIMRF_BIT_HOST] <= 1'b1;
         end else if (wr_go && sel == EIMRF_R_STAT_CLR
                      && PWDATA[`EIMRF_BIT_HOST]) begin
            mac_pend_q[`EIMRF_BIT_HOST] <= 1'b0;
         end
         if (STATS_EVT) begin
            mac_pend_q[`EIMRF_BIT_STAT] <= 1'b1;
         end else if (wr_go && sel == EIMRF_R_STAT_CLR
                      && PWDATA[`EIMRF_BIT_STAT]) begin
            mac_pend_q[`EIMRF_BIT_STAT] <= 1'b0;
         end
      end
   end

   // interrupt line
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         mac_int_q <= 1'b0;
      end else begin
         mac_int_q <= |mac_masked;
      end
   end

   // receive filter configuration, reserved bits never store
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         rx_cfg_q <= `EIMRF_RST_WORD;
      end else if (wr_go && sel == EIMRF_R_RX_CFG) begin
         rx_cfg_q <= PWDATA & `EIMRF_CFG_WMASK;
      end
   end

   // frame decision stage
   assign keep_fcs = rx_cfg_q[`EIMRF_CFG_KEEP_FCS];

   always_comb begin
      if (keep_fcs) begin
         desc_len = FRM_LEN;
      end else if (FRM_LEN > `EIMRF_FCS_BYTES) begin
         desc_len = FRM_LEN - `EIMRF_FCS_BYTES;
      end else begin
         desc_len = 16'h0000;
      end
   end

   always_comb begin
      copy_ok = 1'b1;
      if (FRM_IS_CTRL && !rx_cfg_q[`EIMRF_CFG_COPY_CTRL]) begin
         copy_ok = 1'b0;
      end
      if (FRM_IS_SHORT && !rx_cfg_q[`EIMRF_CFG_COPY_SHORT]) begin
         copy_ok = 1'b0;
      end
      if (FRM_HAS_ERR && !rx_cfg_q[`EIMRF_CFG_COPY_ERR]) begin
         copy_ok = 1'b0;
      end
      if (rx_cfg_q[`EIMRF_CFG_COPY_ALL] && !FRM_IS_CTRL) begin
         copy_ok = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         frm_done_q <= 1'b0;
         frm_store_q <= 1'b0;
         frm_act_pause_q <= 1'b0;
         frm_desc_len_q <= 16'h0000;
         frm_xfer_len_q <= 16'h0000;
      end else begin
         frm_done_q <= FRM_VALID;
         if (FRM_VALID) begin
            frm_store_q <= copy_ok;
            frm_act_pause_q <= FRM_IS_CTRL & FRM_IS_PAUSE
               & PAUSE_ACT_EN;
            frm_desc_len_q <= desc_len;
            if (rx_cfg_q[`EIMRF_CFG_SINGLE_BUF]) begin
               frm_xfer_len_q <= min_len(desc_len, FRM_BUF_LEN);
            end else begin
               frm_xfer_len_q <= desc_len;
            end
         end
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign MAC_INT = mac_int_q;
   assign RX_CHAN_INT_ENABLE = rx_int_enable_q;
   assign RX_FILTER_CFG = rx_cfg_q;
   assign FRM_DONE = frm_done_q;
   assign FRM_STORE = frm_store_q;
   assign FRM_ACT_PAUSE = frm_act_pause_q;
   assign FRM_DESC_LEN = frm_desc_len_q;
   assign FRM_XFER_LEN = frm_xfer_len_q;

endmodule

// *** verilog/eimrf_defs.svh ***
// register offsets, field positions, reset values and counts
`ifndef EIMRF_DEFS_SVH
`define EIMRF_DEFS_SVH

`define EIMRF_OFS_RX_EN_SET 8'h00
`define EIMRF_OFS_RX_DISABLE 8'h04
`define EIMRF_OFS_RAW 8'h08
`define EIMRF_OFS_MASKED 8'h0c
`define EIMRF_OFS_EN_SET 8'h10
`define EIMRF_OFS_EN_CLR 8'h14
`define EIMRF_OFS_STAT_CLR 8'h18
`define EIMRF_OFS_RX_CFG 8'h1c

`define EIMRF_RST_WORD 32'h0000_0000
`define EIMRF_RST_RX_EN 8'h00
`define EIMRF_RST_MAC 2'h0

`define EIMRF_BIT_HOST 1
`define EIMRF_BIT_STAT 0

`define EIMRF_CFG_KEEP_FCS 30
`define EIMRF_CFG_QOS 29
`define EIMRF_CFG_SINGLE_BUF 28
`define EIMRF_CFG_COPY_CTRL 24
`define EIMRF_CFG_COPY_SHORT 23
`define EIMRF_CFG_COPY_ERR 22
`define EIMRF_CFG_COPY_ALL 21
`define EIMRF_CFG_BCAST_EN 13
`define EIMRF_CFG_MCAST_EN 5
`define EIMRF_CFG_WMASK 32'h71e7_2727

`define EIMRF_FCS_BYTES 16'h0004
`define EIMRF_MAX_LEN 16'hffff

`endif

// *** verilog/eimrf_pkg.sv ***
// types shared by the interrupt mask and receive filter block
package eimrf_pkg;

   typedef enum {
      EIMRF_R_RX_EN_SET,
      EIMRF_R_RX_DISABLE,
      EIMRF_R_RAW,
      EIMRF_R_MASKED,
      EIMRF_R_EN_SET,
      EIMRF_R_EN_CLR,
      EIMRF_R_STAT_CLR,
      EIMRF_R_RX_CFG,
      EIMRF_R_NONE
   } eimrf_reg_t;

   typedef logic [31:0] eimrf_word_t;
   typedef logic [15:0] eimrf_len_t;

endpackage

// *** testbench/eimrf_chk.sv ***
// port assertions for the interrupt mask and filter config block
`timescale 1ns/1ps
module eimrf_chk (
   input logic CORE_CLK,
   input logic RESETN,
   input logic PSEL,
   input logic PENABLE,
   input logic PWRITE,
   input logic [7:0] PADDR,
   input logic [31:0] PWDATA,
   input logic [31:0] PRDATA,
   input logic PREADY,
   input logic PSLVERR,
   input logic MAC_INT,
   input logic [7:0] RX_CHAN_INT_ENABLE,
   input logic [31:0] RX_FILTER_CFG
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   wire acc = PSEL && PENABLE && PREADY;
   wire wr = acc && PWRITE;
   a_ready_next: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("ready late");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held");
   a_rx_disable: assert property (
      wr && PADDR == 8'h04 |=> RX_CHAN_INT_ENABLE ==
      ($past(RX_CHAN_INT_ENABLE) & ~$past(PWDATA[7:0])))
      else $error("rx disable wrong");
   a_rx_hold: assert property (
      !(wr && PADDR <= 8'h04) |=> $stable(RX_CHAN_INT_ENABLE))
      else $error("rx mask moved");
   a_resv_zero: assert property (
      acc && !PWRITE |-> !(PADDR == 8'h04 && |PRDATA[31:8]) &&
      !(PADDR inside {8'h08, 8'h0c} && |PRDATA[31:2]))
      else $error("reserved bits set");
   a_cfg_write: assert property (
      wr && PADDR == 8'h1c |=> RX_FILTER_CFG ==
      ($past(PWDATA) & 32'h71e7_2727))
      else $error("config write wrong");
   a_slverr_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
      else $error("error without ready");
   a_reset_zero: assert property (
      disable iff (1'b0) !RESETN |=> !MAC_INT &&
      RX_CHAN_INT_ENABLE == 8'h00 && RX_FILTER_CFG == 32'h0)
      else $error("reset value wrong");
   a_int_clear: assert property (
      wr && PADDR == 8'h14 && PWDATA[1:0] == 2'h3 |-> ##2 !MAC_INT)
      else $error("irq not cleared");
endmodule
bind eimrf_top eimrf_chk chk_u (.*);

// *** testbench/tb_top.sv ***
// self-checking bench for eimrf_top
`timescale 1ns/1ps
module tb_top;
   import eimrf_pkg::*;
   logic CORE_CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd, w, m, x;
   logic PREADY, PSLVERR, MAC_INT, er, HOST_ERR_EVT = 0, STATS_EVT = 0;
   logic [7:0] RX_CHAN_INT_ENABLE;
   logic [31:0] RX_FILTER_CFG;
   logic FRM_VALID = 0, FRM_IS_CTRL = 0, FRM_IS_PAUSE = 0;
   logic FRM_IS_SHORT = 0, FRM_HAS_ERR = 0, PAUSE_ACT_EN = 1;
   logic [15:0] FRM_LEN = 16'h0, FRM_BUF_LEN = 16'h0028;
   logic [15:0] FRM_DESC_LEN, FRM_XFER_LEN;
   logic FRM_DONE, FRM_STORE, FRM_ACT_PAUSE;
   logic [7:0] regs [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
   int err_count = 0, n_checks = 0, seed = 32'h7097;
   eimrf_top dut_u (.*);
   initial begin
      forever #4 CORE_CLK = ~CORE_CLK;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic apb(input logic wi, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      PSEL <= 1'b1;
      PWRITE <= wi;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      i = 0;
      do begin
         @(posedge CORE_CLK);
         i++;
      end while (PREADY !== 1'b1 && i < 20);
      if (PREADY !== 1'b1) begin
         err_count++;
         finish_test();
      end
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CORE_CLK);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic pulse(input logic h, input logic s);
      HOST_ERR_EVT <= h;
      STATS_EVT <= s;
      @(posedge CORE_CLK);
      HOST_ERR_EVT <= 1'b0;
      STATS_EVT <= 1'b0;
      @(posedge CORE_CLK);
   endtask
   task automatic frm(input logic [15:0] len, input logic c,
                      input logic [15:0] ed);
      FRM_VALID <= 1'b1;
      FRM_LEN <= len;
      FRM_IS_CTRL <= c;
      FRM_IS_PAUSE <= c;
      @(posedge CORE_CLK);
      FRM_VALID <= 1'b0;
      #1;
      chk({31'h0, FRM_DONE}, 32'h1);
      chk({16'h0, FRM_DESC_LEN}, {16'h0, ed});
      @(posedge CORE_CLK);
   endtask
   function automatic logic [31:0] cfg_exp(input logic [31:0] v);
      return {1'b0, v[30:28], 3'h0, v[24:21], 2'h0, v[18:16], 2'h0, v[13],
         2'h0, v[10:8], 2'h0, v[5], 2'h0, v[2:0]};
   endfunction
   initial begin
      repeat (8) @(posedge CORE_CLK);
      RESETN <= 1'b1;
      @(posedge CORE_CLK);
      foreach (regs[k]) rdc(regs[k], 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, er}, 32'h1);
      for (int k = 0; k < 4; k++) begin
         w = $random(seed);
         m = $random(seed);
         x = {24'h0, w[7:0] & ~m[7:0]};
         apb(1'b1, 8'h00, w);
         apb(1'b1, 8'h04, m);
         rdc(8'h04, x);
         chk({24'h0, RX_CHAN_INT_ENABLE}, x);
         apb(1'b1, 8'h04, 32'hffff_ffff);
      end
      pulse(1'b1, 1'b0);
      rdc(8'h08, 32'h2);
      pulse(1'b0, 1'b1);
      rdc(8'h08, 32'h3);
      rdc(8'h0c, 32'h0);
      chk({31'h0, MAC_INT}, 32'h0);
      apb(1'b1, 8'h10, 32'hffff_fffe);
      rdc(8'h0c, 32'h2);
      rdc(8'h14, 32'h2);
      chk({31'h0, MAC_INT}, 32'h1);
      apb(1'b1, 8'h10, 32'h1);
      rdc(8'h0c, 32'h3);
      apb(1'b1, 8'h14, 32'h2);
      rdc(8'h0c, 32'h1);
      rdc(8'h10, 32'h1);
      apb(1'b1, 8'h14, 32'h3);
      rdc(8'h0c, 32'h0);
      chk({31'h0, MAC_INT}, 32'h0);
      for (int k = 0; k < 6; k++) begin
         w = (k == 0) ? 32'hffff_ffff : $random(seed);
         apb(1'b1, 8'h1c, w);
         rdc(8'h1c, cfg_exp(w));
         chk(RX_FILTER_CFG, cfg_exp(w));
      end
      apb(1'b1, 8'h1c, 32'h0);
      frm(16'd100, 1'b0, 16'd96);
      frm(16'd100, 1'b1, 16'd96);
      chk({30'h0, FRM_STORE, FRM_ACT_PAUSE}, 32'h1);
      apb(1'b1, 8'h1c, 32'h5100_0000);
      frm(16'd100, 1'b0, 16'd100);
      chk({16'h0, FRM_XFER_LEN}, 32'd40);
      frm(16'd100, 1'b1, 16'd100);
      chk({30'h0, FRM_STORE, FRM_ACT_PAUSE}, 32'h3);
      finish_test();
   end
endmodule
